// *** tcc_top.sv ***
// Timer with 8 capture/compare channels and a 16-bit pulse accumulator.
// Assumes pins synchronous to clk except the accumulator input, which is synchronised.
`timescale 1ns/10ps
module tcc_top import tcc_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Channel pins
  input  wire logic [7:0]  chan_in,
  output logic [7:0]       chan_out,
  output logic [7:0]       chan_oe,
  // Interrupt requests
  output logic [3:0]       irq_channel,
  output logic             irq_accum_input,
  output logic             irq_accum_overflow,
  output logic             irq_counter_wrap
);
  // Software registers
  logic        timer_enable_bit_r, fast_flag_clear_enable_r, counter_wrap_irq_enable_r;
  logic [7:0]  channel_irq_enable_r, channel_direction_select_r;
  logic [2:0]  divider_select_r;
  logic        counter_reset_on_ch7_r;
  logic [7:0]  output_action_mode_r, output_action_level_r, ch7_mask_r, ch7_data_r;
  logic [7:0]  port_latch_r;
  logic        accum_mode_select_r, accum_edge_select_r;
  logic        accum_overflow_irq_enable_r, accum_input_irq_enable_r;
  logic [15:0] channel_value_r [8];
  // Block state
  logic [15:0] counter_r, pulse_count_r;
  logic [6:0]  presc_r;
  logic [7:0]  channel_event_flag_r, pin_r, chan_q_r;
  logic        counter_wrap_flag_r, accum_overflow_flag_r, accum_input_flag_r;
  logic [1:0]  acc_sync_r;
  logic        acc_q_r;
  // Bus state
  logic        aw_got_r, w_got_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  // Channel value words sit in one aligned block; the index is the word offset
  function automatic logic hit_chv(input logic [7:0] a);
    return a[7:5] == TCC_A_CHV0[7:5];
  endfunction

  // Write path: address and data may arrive in either order
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  wire        wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  wire [2:0]  wr_idx  = awaddr_r[4:2];
  wire        wr_chv  = hit_chv(awaddr_r);
  wire        wr_full = wstrb_r[1:0] == 2'h3;
  wire [15:0] wd      = wdata_r[15:0];
  function automatic logic wr_at(input logic [7:0] a, input logic f, input logic [7:0] adr);
    return f && (adr == a);
  endfunction
  wire wr_known = wr_chv || awaddr_r inside {TCC_A_CTRL1, TCC_A_CTRL2, TCC_A_DIR, TCC_A_ACTION,
                  TCC_A_FORCE, TCC_A_CH7, TCC_A_FLAGS, TCC_A_CNT, TCC_A_PORT, TCC_A_ACTL,
                  TCC_A_AFLG, TCC_A_PCNT};

  // Read path: answer one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  wire       rd_fire = s_axi_arvalid && s_axi_arready;
  wire [2:0] rd_idx  = s_axi_araddr[4:2];
  wire       rd_chv  = hit_chv(s_axi_araddr);
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0;
    if (rd_chv) begin
      rd_mux = {16'h0, channel_value_r[rd_idx]};
    end else begin
      case (s_axi_araddr)
        TCC_A_CTRL1:  rd_mux = {21'h0, counter_wrap_irq_enable_r, fast_flag_clear_enable_r,
                                timer_enable_bit_r, channel_irq_enable_r};
        TCC_A_CTRL2:  rd_mux = {28'h0, counter_reset_on_ch7_r, divider_select_r};
        TCC_A_DIR:    rd_mux = {24'h0, channel_direction_select_r};
        TCC_A_ACTION: rd_mux = {16'h0, output_action_level_r, output_action_mode_r};
        TCC_A_CH7:    rd_mux = {16'h0, ch7_data_r, ch7_mask_r};
        TCC_A_FLAGS:  rd_mux = {23'h0, counter_wrap_flag_r, channel_event_flag_r};
        TCC_A_CNT:    rd_mux = {16'h0, counter_r};
        TCC_A_PORT:   rd_mux = {16'h0, pin_r, port_latch_r};
        TCC_A_ACTL:   rd_mux = {28'h0, accum_mode_select_r, accum_edge_select_r,
                                accum_overflow_irq_enable_r, accum_input_irq_enable_r};
        TCC_A_AFLG:   rd_mux = {30'h0, accum_overflow_flag_r, accum_input_flag_r};
        TCC_A_PCNT:   rd_mux = {16'h0, pulse_count_r};
        TCC_A_FORCE:  rd_mux = 32'h0;
        default:      rd_ok  = 1'b0;
      endcase
    end
  end

  // Prescaler and timer ticks
  wire       timer_tick = timer_enable_bit_r &&
                          ((divider_select_r == 3'h0) ||
                           (presc_r & ((7'h1 << divider_select_r) - 7'h1)) == 7'h0);
  // One gate tick per 64 clocks, taken from the same prescaler as the timer
  wire       gate_tick  = timer_enable_bit_r &&
                          (presc_r & ~(7'h7f << TCC_GATE_DIV)) == 7'h0;
  wire       ch7_match  = timer_tick && channel_direction_select_r[7] &&
                          (counter_r == channel_value_r[7]);

  // Channel events
  wire [7:0] cap_edge;
  wire [7:0] cmp_match;
  wire [7:0] force_wr = wr_at(TCC_A_FORCE, wr_fire, awaddr_r) ? wdata_r[7:0] : 8'h0;
  wire [7:0] disc     = ~(output_action_mode_r | output_action_level_r);
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ch
      // Both edges capture; only level changes seen at the clock count
      assign cap_edge[g]  = !channel_direction_select_r[g] && (chan_in[g] != chan_q_r[g]);
      assign cmp_match[g] = timer_tick && channel_direction_select_r[g] &&
                            (counter_r == channel_value_r[g]);
    end
  endgenerate

  // Pin action for one channel from its mode and level bits
  function automatic logic act(input logic m, input logic l, input logic p);
    case ({m, l})
      2'b01:   return !p;
      2'b10:   return 1'b0;
      2'b11:   return 1'b1;
      default: return p;
    endcase
  endfunction
  logic [7:0] pin_nxt;
  always_comb begin
    pin_nxt = pin_r;
    for (int i = 0; i < 7; i++) begin
      if ((cmp_match[i] || force_wr[i]) && !disc[i]) begin
        pin_nxt[i] = act(output_action_mode_r[i], output_action_level_r[i], pin_r[i]);
      end
    end
    if ((cmp_match[7] || force_wr[7]) && !disc[7]) begin
      pin_nxt[7] = act(output_action_mode_r[7], output_action_level_r[7], pin_r[7]);
    end
    if (ch7_match || force_wr[7]) begin
      pin_nxt = (pin_nxt & ~ch7_mask_r) | (ch7_data_r & ch7_mask_r);
    end
  end
  // Pins owned by compare show the compare state; others show the latch
  wire [7:0] owned = (channel_direction_select_r & ~disc) | ch7_mask_r;
  assign chan_out = (owned & pin_r) | (~owned & port_latch_r);
  assign chan_oe  = owned | channel_direction_select_r;

  // Pulse accumulator
  wire acc_pin    = acc_sync_r[1];
  wire acc_rise   = acc_pin && !acc_q_r;
  wire acc_fall   = !acc_pin && acc_q_r;
  wire acc_evt    = accum_edge_select_r ? acc_rise : acc_fall;
  wire acc_active = accum_edge_select_r ? !acc_pin : acc_pin;
  wire acc_trail  = accum_edge_select_r ? acc_rise : acc_fall;
  wire acc_inc    = accum_mode_select_r ? (acc_active && gate_tick) : acc_evt;
  wire acc_wrap   = acc_inc && (pulse_count_r == 16'hffff);
  wire acc_in_set = accum_mode_select_r ? acc_trail : acc_evt;
  wire pcnt_acc   = wr_at(TCC_A_PCNT, wr_fire, awaddr_r) ||
                    (rd_fire && rd_ok && s_axi_araddr == TCC_A_PCNT);
  wire fast_clr   = fast_flag_clear_enable_r && pcnt_acc;
  wire aflg_wr    = wr_at(TCC_A_AFLG, wr_fire, awaddr_r) && wstrb_r[0];
  wire flg_wr     = wr_at(TCC_A_FLAGS, wr_fire, awaddr_r);
  wire ctr_wrap   = timer_tick && !(ch7_match && counter_reset_on_ch7_r) &&
                    (counter_r == 16'hffff);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_sync_r <= 2'h0;
      acc_q_r    <= 1'b0;
      chan_q_r   <= 8'h0;
    end else begin
      acc_sync_r <= {acc_sync_r[0], chan_in[7]};
      acc_q_r    <= acc_sync_r[1];
      chan_q_r   <= chan_in;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      presc_r   <= 7'h0;
      counter_r <= TCC_RST16;
      pin_r     <= 8'h0;
    end else begin
      presc_r <= timer_enable_bit_r ? presc_r + 7'h1 : 7'h0;
      pin_r   <= pin_nxt;
      if (wr_at(TCC_A_CNT, wr_fire, awaddr_r) && wr_full) begin
        counter_r <= wd;
      end else if (ch7_match && counter_reset_on_ch7_r) begin
        counter_r <= TCC_RST16;
      end else if (timer_tick) begin
        counter_r <= counter_r + 16'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pulse_count_r <= TCC_RST16;
    end else if (wr_at(TCC_A_PCNT, wr_fire, awaddr_r) && wr_full) begin
      pulse_count_r <= wd;
    end else if (acc_inc) begin
      pulse_count_r <= pulse_count_r + 16'h1;
    end
  end

  // Flags: hardware set wins over software clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accum_overflow_flag_r <= 1'b0;
      accum_input_flag_r    <= 1'b0;
      channel_event_flag_r  <= 8'h0;
      counter_wrap_flag_r   <= 1'b0;
    end else begin
      accum_overflow_flag_r <= acc_wrap || (accum_overflow_flag_r && !fast_clr &&
                               !(aflg_wr && wdata_r[TCC_BIT_OVF]));
      accum_input_flag_r    <= acc_in_set || (accum_input_flag_r && !fast_clr &&
                               !(aflg_wr && wdata_r[TCC_BIT_IN]));
      channel_event_flag_r  <= (cap_edge | cmp_match) | (channel_event_flag_r &
                               ~(flg_wr && wstrb_r[0] ? wdata_r[7:0] : 8'h0));
      counter_wrap_flag_r   <= ctr_wrap || (counter_wrap_flag_r &&
                               !(flg_wr && wstrb_r[1] && wdata_r[8]));
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (sys_rst) begin
        channel_value_r[i] <= TCC_RST16;
      end else if (cap_edge[i]) begin
        channel_value_r[i] <= counter_r;
      end else if (wr_fire && wr_chv && wr_idx == 3'(i) && wr_full) begin
        channel_value_r[i] <= wd;
      end
    end
  end

  // Software register writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {counter_wrap_irq_enable_r, fast_flag_clear_enable_r, timer_enable_bit_r} <= 3'h0;
      channel_irq_enable_r       <= 8'h0;
      {counter_reset_on_ch7_r, divider_select_r} <= 4'h0;
      channel_direction_select_r <= 8'h0;
      {output_action_level_r, output_action_mode_r} <= 16'h0;
      {ch7_data_r, ch7_mask_r}   <= 16'h0;
      port_latch_r               <= 8'h0;
      {accum_mode_select_r, accum_edge_select_r} <= 2'h0;
      {accum_overflow_irq_enable_r, accum_input_irq_enable_r} <= 2'h0;
    end else if (wr_fire) begin
      case (awaddr_r)
        TCC_A_CTRL1:  {counter_wrap_irq_enable_r, fast_flag_clear_enable_r,
                       timer_enable_bit_r, channel_irq_enable_r} <= wdata_r[10:0];
        TCC_A_CTRL2:  {counter_reset_on_ch7_r, divider_select_r} <= wdata_r[3:0];
        TCC_A_DIR:    channel_direction_select_r <= wdata_r[7:0];
        TCC_A_ACTION: {output_action_level_r, output_action_mode_r} <= wd;
        TCC_A_CH7:    {ch7_data_r, ch7_mask_r} <= wd;
        TCC_A_PORT:   port_latch_r <= wdata_r[7:0];
        TCC_A_ACTL:   {accum_mode_select_r, accum_edge_select_r, accum_overflow_irq_enable_r,
                       accum_input_irq_enable_r} <= wdata_r[3:0];
        default:      port_latch_r <= port_latch_r;
      endcase
    end
  end

  // Bus handshakes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      awaddr_r     <= 8'h0;
      wdata_r      <= 32'h0;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= TCC_RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= TCC_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? TCC_RESP_OK : TCC_RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? TCC_RESP_OK : TCC_RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Interrupts
  assign irq_channel        = channel_event_flag_r[7:4] & channel_irq_enable_r[7:4];
  assign irq_accum_input    = accum_input_flag_r && accum_input_irq_enable_r;
  assign irq_accum_overflow = accum_overflow_flag_r && accum_overflow_irq_enable_r;
  assign irq_counter_wrap   = counter_wrap_flag_r && counter_wrap_irq_enable_r;

  // Checks
  sequence s_acc_top;
    accum_mode_select_r == 1'b0 && acc_inc && pulse_count_r == 16'hffff;
  endsequence
  a_accum_wrap_flag: assert property (@(posedge clk) disable iff (sys_rst)
    s_acc_top |=> accum_overflow_flag_r && pulse_count_r == 16'h0)
    else $error("accumulator wrap did not set overflow flag");
  a_accum_sync_delay: assert property (@(posedge clk) disable iff (sys_rst)
    acc_inc && !accum_mode_select_r |-> $past(chan_in[7], 2) != $past(chan_in[7], 3))
    else $error("accumulator counted without a synchronised edge");
  a_capture_value: assert property (@(posedge clk) disable iff (sys_rst)
    cap_edge[1] |=> channel_value_r[1] == $past(counter_r))
    else $error("capture did not store counter");
  a_event_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (cap_edge[4] || cmp_match[4]) |=> channel_event_flag_r[4])
    else $error("channel event did not set flag");
  a_force_noflag: assert property (@(posedge clk) disable iff (sys_rst)
    force_wr[0] && !cmp_match[0] && !cap_edge[0] && !channel_event_flag_r[0]
    |=> !channel_event_flag_r[0])
    else $error("forced compare set the flag");
  a_ch7_reset: assert property (@(posedge clk) disable iff (sys_rst)
    ch7_match && counter_reset_on_ch7_r && !wr_fire |=> counter_r == 16'h0)
    else $error("channel 7 match did not reset counter");
  a_gate_stops: assert property (@(posedge clk) disable iff (sys_rst)
    (accum_mode_select_r && !timer_enable_bit_r)[*2] |-> $stable(pulse_count_r) || pcnt_acc
    || $past(pcnt_acc))
    else $error("gated count ran with timer disabled");
  a_fast_clear: assert property (@(posedge clk) disable iff (sys_rst)
    fast_clr && !acc_wrap && !acc_in_set |=> !accum_overflow_flag_r && !accum_input_flag_r)
    else $error("fast clear missed accumulator flags");
  a_wrap_irq: assert property (@(posedge clk) disable iff (sys_rst)
    ctr_wrap && counter_wrap_irq_enable_r |=> irq_counter_wrap)
    else $error("counter wrap interrupt missing");
  a_ch7_override: assert property (@(posedge clk) disable iff (sys_rst)
    ch7_match |=> ((pin_r ^ $past(ch7_data_r)) & $past(ch7_mask_r)) == 8'h0)
    else $error("channel 7 match did not drive masked pins");
  a_event_count: assert property (@(posedge clk) disable iff (sys_rst)
    !accum_mode_select_r && acc_evt && !pcnt_acc |=> pulse_count_r == $past(pulse_count_r) + 16'h1)
    else $error("event edge did not advance pulse count");
  a_port_latch: assert property (@(posedge clk) disable iff (sys_rst)
    wr_at(TCC_A_PORT, wr_fire, awaddr_r) && owned[0] |=> chan_out[0] == $past(pin_nxt[0]))
    else $error("port write reached a compare-owned pin");
  sequence s_gate_trail;
    accum_mode_select_r && !accum_edge_select_r && acc_fall;
  endsequence
  a_gate_trail_flag: assert property (@(posedge clk) disable iff (sys_rst)
    s_gate_trail |=> accum_input_flag_r)
    else $error("gated trailing edge did not set input flag");
endmodule

// *** tcc_pkg.sv ***
// Constants for the timer capture/compare/accumulator block.
// Assumes AXI4-Lite access with 32-bit data, one register per aligned word.
package tcc_pkg;
  localparam logic [7:0]  TCC_A_CTRL1  = 8'h00; // timer_enable, fast clear, irq enables
  localparam logic [7:0]  TCC_A_CTRL2  = 8'h04; // divider_select, counter reset
  localparam logic [7:0]  TCC_A_DIR    = 8'h08;
  localparam logic [7:0]  TCC_A_ACTION = 8'h0c; // {level[7:0], mode[7:0]}
  localparam logic [7:0]  TCC_A_FORCE  = 8'h10;
  localparam logic [7:0]  TCC_A_CH7    = 8'h14; // {data[15:8], mask[7:0]}
  localparam logic [7:0]  TCC_A_FLAGS  = 8'h18; // {wrap[8], channel[7:0]}
  localparam logic [7:0]  TCC_A_CNT    = 8'h1c;
  localparam logic [7:0]  TCC_A_PORT   = 8'h20;
  localparam logic [7:0]  TCC_A_ACTL   = 8'h24; // mode, edge, ovf ie, in ie
  localparam logic [7:0]  TCC_A_AFLG   = 8'h28;
  localparam logic [7:0]  TCC_A_PCNT   = 8'h2c;
  localparam logic [7:0]  TCC_A_CHV0   = 8'h40; // channel values, 4 bytes apart
  localparam int          TCC_BIT_OVF  = 1;
  localparam int          TCC_BIT_IN   = 0;
  localparam logic [2:0]  TCC_GATE_DIV = 3'h6; // 2^6 = 64
  localparam logic [15:0] TCC_RST16    = 16'h0000;
  localparam logic [1:0]  TCC_RESP_OK  = 2'h0;
  localparam logic [1:0]  TCC_RESP_ERR = 2'h2;
endpackage

// *** tcc_pin_model.sv ***
// Pin-side model: external event sources on the channel input pins.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/10ps
module tcc_pin_model (
  // Clock
  input  wire logic clk,
  // Pins
  output logic [7:0] chan_in
);
  initial chan_in = 8'h00;

  // Short pulses are stretched, a pulse is held for at least three cycles
  task automatic pulse(input int ch, input int w);
    chan_in[ch] <= ~chan_in[ch];
    repeat ((w < 3) ? 3 : w) @(posedge clk);
    chan_in[ch] <= ~chan_in[ch];
    @(posedge clk);
  endtask

  task automatic lvl(input int ch, input logic v);
    chan_in[ch] <= v;
    @(posedge clk);
  endtask
endmodule

// *** tcc_top_tb_top.sv ***
// Self-checking bench for the timer capture/compare/accumulator block.
// Assumes an AXI4-Lite master here and the pin model on chan_in.
`timescale 1ns/10ps
module tcc_top_tb_top;
  import tcc_pkg::*;
  logic clk, sys_rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] chan_in, chan_out, chan_oe;
  wire [3:0] irq_channel;
  wire irq_accum_input, irq_accum_overflow, irq_counter_wrap;
  int error_cnt, checks_done, cyc_cnt;
  logic [1:0]  last_resp;
  logic [31:0] d;

  tcc_top tcc_top_inst (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .chan_in(chan_in),
    .chan_out(chan_out), .chan_oe(chan_oe), .irq_channel(irq_channel),
    .irq_accum_input(irq_accum_input), .irq_accum_overflow(irq_accum_overflow),
    .irq_counter_wrap(irq_counter_wrap));
  tcc_pin_model tcc_pin_model_inst (.clk(clk), .chan_in(chan_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("errors %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cuts a hang short; the full run needs well under two thousand cycles
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Both channels offered together; bready held until the answer is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check(v, exp);
  endtask

  logic [15:0] act[4] = '{16'h0101, 16'h0100, 16'h0100, 16'h0001};
  logic        exo[4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    sys_rst = 1'b1;
    cyc(5);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdc(TCC_A_PCNT, 32'h0);
    rdc(TCC_A_AFLG, 32'h0);
    rdc(8'h30, 32'h0);
    check(last_resp, TCC_RESP_ERR);
    wr(8'h30, 32'h0);
    check(last_resp, TCC_RESP_ERR);
    // Capture with the timer stopped gives a known counter value
    wr(TCC_A_CNT, 32'h1234);
    check(last_resp, TCC_RESP_OK);
    tcc_pin_model_inst.pulse(1, 3);
    cyc(3);
    rdc(TCC_A_CHV0 + 8'h04, 32'h1234);
    rd(TCC_A_FLAGS, d);
    check(d[1], 1'b1);
    // Event mode, timer disabled: one falling then one rising edge
    tcc_pin_model_inst.pulse(7, 3);
    wr(TCC_A_ACTL, 32'h6);
    tcc_pin_model_inst.pulse(7, 3);
    cyc(6);
    rdc(TCC_A_PCNT, 32'h2);
    wr(TCC_A_PCNT, 32'hffff);
    tcc_pin_model_inst.pulse(7, 3);
    cyc(6);
    rdc(TCC_A_PCNT, 32'h0);
    rdc(TCC_A_AFLG, 32'h3);
    check(irq_accum_overflow, 1'b1);
    wr(TCC_A_AFLG, 32'h1);
    rdc(TCC_A_AFLG, 32'h2);
    wr(TCC_A_CTRL1, 32'h200);
    rdc(TCC_A_PCNT, 32'h0);
    rdc(TCC_A_AFLG, 32'h0);
    check(irq_accum_overflow, 1'b0);
    // Forced actions on channel 0: set, toggle, toggle, clear
    wr(TCC_A_CTRL1, 32'h0);
    wr(TCC_A_FLAGS, 32'h1ff);
    wr(TCC_A_DIR, 32'h01);
    for (int i = 0; i < 4; i++) begin
      wr(TCC_A_ACTION, {16'h0, act[i]});
      wr(TCC_A_FORCE, 32'h01);
      cyc(2);
      check(chan_out[0], exo[i]);
    end
    wr(TCC_A_PORT, 32'h01);
    check(chan_out[0], 1'b0);
    rd(TCC_A_FLAGS, d);
    check(d[0], 1'b0);
    check(chan_oe[0], 1'b1);
    // Channel 4 sets its pin; channel 7 drives pin 5 and restarts the counter
    wr(TCC_A_DIR, 32'h90);
    wr(TCC_A_ACTION, 32'h1010);
    wr(TCC_A_CHV0 + 8'h10, 32'h0020);
    wr(TCC_A_CHV0 + 8'h1c, 32'h0040);
    wr(TCC_A_CH7, 32'h2020);
    wr(TCC_A_CTRL2, 32'h8);
    wr(TCC_A_CNT, 32'h0);
    wr(TCC_A_CTRL1, 32'h110);
    cyc(200);
    check({chan_out[4], chan_oe[4], irq_channel[0]}, 3'b111);
    check({chan_out[5], chan_oe[5]}, 2'b11);
    check(chan_out[0], 1'b1);
    rd(TCC_A_CNT, d);
    check(d[15:0] <= 16'h0040, 1'b1);
    rd(TCC_A_FLAGS, d);
    check({d[8], d[7], d[4]}, 3'b011);
    // Wrap of the main counter
    wr(TCC_A_CTRL2, 32'h0);
    wr(TCC_A_FLAGS, 32'h1ff);
    wr(TCC_A_CNT, 32'hfff0);
    wr(TCC_A_CTRL1, 32'h500);
    cyc(40);
    check(irq_counter_wrap, 1'b1);
    rd(TCC_A_FLAGS, d);
    check(d[8], 1'b1);
    // Divide by 8: the 82 clocks before the read hold 10 or 11 ticks
    wr(TCC_A_CTRL2, 32'h3);
    wr(TCC_A_CNT, 32'h0);
    cyc(80);
    rd(TCC_A_CNT, d);
    check(d[15:0] >= 16'd10 && d[15:0] <= 16'd11, 1'b1);
    // Gated mode, high level active: no ticks while the timer is off
    wr(TCC_A_CTRL1, 32'h0);
    wr(TCC_A_ACTL, 32'h9);
    wr(TCC_A_PCNT, 32'h0);
    wr(TCC_A_AFLG, 32'h3);
    tcc_pin_model_inst.pulse(7, 200);
    cyc(6);
    rdc(TCC_A_PCNT, 32'h0);
    rdc(TCC_A_AFLG, 32'h1);
    check(irq_accum_input, 1'b1);
    wr(TCC_A_CTRL1, 32'h100);
    tcc_pin_model_inst.pulse(7, 640);
    cyc(6);
    rd(TCC_A_PCNT, d);
    check(d >= 32'd9 && d <= 32'd11, 1'b1);
    end_of_test();
  end
endmodule
